// ### bench/tb_two_wire_bus_protocol_engine.sv
/*
 * Bench: node as master writes to and reads from the partner slave.
 * Assumes the design files and bus interface are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none

module tb_two_wire_bus_protocol_engine;
	logic clk = 1'h0;
	logic rstn = 1'h0;
	logic txValid = 1'h0, txLast = 1'h0, nRxReady = 1'h0, pRxReady = 1'h0, pTxValid = 1'h0;
	logic [7:0] txData = 8'h00, pTxData = 8'h00;
	logic txReady, nRxValid, busBusy, nackSeen, pRxValid, pTxReady, pSel;
	logic [7:0] nRxData, pRxData;
	logic nArb, nSel, arbSeen = 1'h0;
	int bad_count = 0, n_compared = 0;
	wire logic [5:0] st = {pTxReady, nackSeen, txReady, busBusy, nRxValid, pRxValid};

	// ==========
	// Both ends on one bus, checker beside it
	twi_bus_if bus();
	twi_node #(.HALF_CYC(16'h0008)) twi_node_inst (.clk(clk), .rstn(rstn), .ce(1'h1), .bus(bus),
		.txValid(txValid), .txReady(txReady), .txData(txData), .txLast(txLast),
		.rxValid(nRxValid), .rxReady(nRxReady), .rxData(nRxData), .busBusy(busBusy),
		.arbLost(nArb), .nackSeen(nackSeen), .selected(nSel));
	twi_partner twi_partner_inst (.clk(clk), .rstn(rstn), .ce(1'h1), .bus(bus),
		.rxValid(pRxValid), .rxReady(pRxReady), .rxData(pRxData), .txValid(pTxValid),
		.txReady(pTxReady), .txData(pTxData), .selected(pSel));
	twi_bus_props twi_bus_props_inst (.clk(clk), .rstn(rstn), .devSclOe(bus.devSclOe),
		.devSdaOe(bus.devSdaOe), .farSclOe(bus.farSclOe), .farSdaOe(bus.farSdaOe),
		.scl(bus.scl), .sda(bus.sda));

	// ==========
	// Tasks
	// Prints the counts and the verdict, then ends the run.
	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Compares one byte and counts it.
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask

	// Waits at falling edges, where values are settled, for a status bit.
	task automatic waitSt(input int i, input logic v);
		int n;
		for (n = 0; n < 9999; n++) begin
			@(negedge clk);
			if (st[i] === v) break;
		end
		if (n == 9999) begin
			bad_count++;
			$display("BAD %0t wait %0d timed out", $time, i);
			report_and_stop();
		end
	endtask

	// Offers one word to the node and holds it until taken.
	task automatic send(input logic [7:0] b, input logic l);
		@(posedge clk);
		txValid <= 1'h1;
		txData <= b;
		txLast <= l;
		waitSt(3, 1'h1);
		@(posedge clk);
		txValid <= 1'h0;
	endtask

	// Takes one received byte from the partner (0) or the node (1).
	task automatic take(input int i, input logic [7:0] exp);
		waitSt(i, 1'h1);
		cmp(i ? nRxData : pRxData, exp);
		@(posedge clk);
		{nRxReady, pRxReady} <= i ? 2'h2 : 2'h1;
		@(posedge clk);
		{nRxReady, pRxReady} <= 2'h0;
	endtask

	// ==========
	// Clock and test sequence
	initial begin
		forever #2.5 clk = ~clk;
	end

	// Keeps any arbitration-loss pulse for the closing check; one master must never lose.
	always @(posedge clk) begin
		if (nArb) begin
			arbSeen <= 1'h1;
		end
	end

	// Write with a stalled receiver, read of two bytes, refused address.
	initial begin
		repeat (12) @(posedge clk);
		rstn <= 1'h1;
		repeat (3) @(posedge clk);
		fork
			begin
				send(8'ha2, 1'h0);
				send(8'h3c, 1'h0);
				send(8'hc5, 1'h1);
			end
			begin
				waitSt(0, 1'h1);
				repeat (400) @(posedge clk);
				@(negedge clk);
				cmp({5'h0, bus.scl, bus.farSclOe, pSel}, 8'h03);
				take(0, 8'h3c);
				take(0, 8'hc5);
			end
		join
		waitSt(2, 1'h0);
		cmp({6'h0, bus.scl, bus.sda}, 8'h03);
		$display("test write done");
		fork
			begin
				send(8'ha3, 1'h0);
				send(8'h00, 1'h0);
				send(8'h00, 1'h1);
			end
			begin
				@(posedge clk);
				pTxData <= 8'h96;
				pTxValid <= 1'h1;
				waitSt(5, 1'h1);
				@(posedge clk);
				pTxData <= 8'h5a;
				waitSt(5, 1'h1);
				@(posedge clk);
				pTxValid <= 1'h0;
			end
			begin
				waitSt(2, 1'h1);
				waitSt(2, 1'h0);
				take(1, 8'h96);
				take(1, 8'h5a);
			end
		join
		$display("test read done");
		send(8'h66, 1'h1);
		waitSt(4, 1'h1);
		cmp({7'h0, pSel}, 8'h00);
		waitSt(2, 1'h0);
		cmp({6'h0, bus.scl, bus.sda}, 8'h03);
		cmp({6'h0, arbSeen, nSel}, 8'h00);
		$display("test refused address done");
		report_and_stop();
	end
endmodule // tb_two_wire_bus_protocol_engine

`default_nettype wire

// ### bench/twi_bus_props.sv
/*
 * Line checker for the two-wire bus between the node and its partner.
 * Assumes the bench instantiates it beside the interface, SCL half period 8.
 */
`timescale 1ns/100ps
`default_nettype none

module twi_bus_props (
	input wire logic clk, // System clock.
	input wire logic rstn, // Reset, active low.
	input wire logic devSclOe, // Node pulls SCL low.
	input wire logic devSdaOe, // Node pulls SDA low.
	input wire logic farSclOe, // Partner pulls SCL low.
	input wire logic farSdaOe, // Partner pulls SDA low.
	input wire logic scl, // Resolved SCL level.
	input wire logic sda // Resolved SDA level.
);
	// ==========
	// Line events
	// Both conditions are SDA edges while SCL stays high.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence startCond; scl && $fell(sda); endsequence
	sequence stopCond; scl && $rose(sda); endsequence

	// ==========
	// Assertions
	// Each ties a line event or level to what the ends drive or to its timing.
	AST_START_BY_MASTER: assert property (startCond |-> devSdaOe && !farSdaOe)
		else $error("start not made by the master");
	AST_START_CLOCKS: assert property (startCond |-> ##[1:40] !scl)
		else $error("no clock after start");
	AST_SDA_STABLE: assert property (scl && $past(scl) && $changed(sda) |-> $changed(devSdaOe) && !farSdaOe)
		else $error("data moved while clock high");
	AST_ACK_HOLD: assert property (farSdaOe && $rose(scl) |-> farSdaOe[*4])
		else $error("partner low bit dropped early");
	AST_STRETCH_LOW: assert property ($rose(farSclOe) |-> !$past(scl))
		else $error("stretch pulled a high clock");
	AST_STOP_IDLE: assert property (stopCond |-> (scl && sda)[*8])
		else $error("lines not idle after stop");
	AST_HIGH_PHASE: assert property ($rose(scl) |-> scl[*4])
		else $error("clock high phase too short");
	AST_OPEN_DRAIN: assert property (devSclOe || farSclOe |-> !scl)
		else $error("driven clock line not low");
endmodule // twi_bus_props

`default_nettype wire

// ### logic/twi_bus_if.sv
/*
 * The two shared open-drain lines between the node and its partner.
 * Assumes external pull-ups: a line reads high unless some end drives it.
 */
`timescale 1ns/100ps
`default_nettype none

interface twi_bus_if;
	logic devSclOut;
	logic devSclOe;
	logic devSdaOut;
	logic devSdaOe;
	logic farSclOut;
	logic farSclOe;
	logic farSdaOut;
	logic farSdaOe;
	logic scl;
	logic sda;

	// Wired-AND resolution of both ends with a pull-up to high.
	assign scl = (devSclOe ? devSclOut : 1'h1) & (farSclOe ? farSclOut : 1'h1);
	assign sda = (devSdaOe ? devSdaOut : 1'h1) & (farSdaOe ? farSdaOut : 1'h1);

	modport dev(output devSclOut, devSclOe, devSdaOut, devSdaOe, input scl, sda);
	modport far(output farSclOut, farSclOe, farSdaOut, farSdaOe, input scl, sda);
endinterface

`default_nettype wire

// ### logic/twi_node.sv
/*
 * Two-wire bus node: master transmitter or receiver and addressed slave.
 * Assumes SCL and SDA arrive asynchronously through the bus interface and
 * that the user side runs on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

// What this block does
// [R1] Idle bus: both lines released, resting high.
// [R2] Master alone makes start, stop, SCL.
// [R3] First byte: 7-bit address, direction bit.
// [R4] General call selects all; reserved never own.
// [R5] Eight data bits, ninth clock acknowledges.
// [R6] Addressed slave pulls SDA low ninth clock.
// [R7] Transmitting master releases SDA ninth clock.
// [R8] Receiving slave acknowledges every data byte.
// [R9] Unbounded bytes; only stop ends transfer.
// [R10] Master holds SCL low until next byte.
// [R11] Stop: SCL low, release, then SDA rises.
// [R12] Busy slave stretches SCL; master waits.
// [R13] Stretch starts only in master's low phase.
// [R14] Master starts only after bus seen idle.
// [R15] Reading low while sending high loses arbitration.
// [R16] Arbitration compare continues through data bytes.
// [R17] Lower value wins; general call strongest.
// [R18] Seven-bit addressing only, no 10-bit.
// [R19] Matching write address enters slave reception.
// [R20] Busy from start until stop observed.
// [R21] Start: SDA falls while SCL high.
// [R22] SDA changes only while SCL low.
// [R23] Open-drain drive, decisions from line readback.
module twi_node #(
	parameter logic [6:0] OWN_ADDR = 7'h2a,
	parameter logic GC_EN = 1'h1,
	parameter logic [15:0] HALF_CYC = 16'(twi_pkg::SCL_HALF_CYC)
) (
	input wire logic clk, // System clock.
	input wire logic rstn, // Synchronous reset, active low.
	input wire logic ce, // Clock enable; low freezes all state.
	twi_bus_if.dev bus, // Shared SCL and SDA lines.
	input wire logic txValid, // Byte offered to send.
	output logic txReady, // Ready: an offered byte is taken this cycle.
	input wire logic [7:0] txData, // Address or data byte.
	input wire logic txLast, // Master: stop after this byte.
	output logic rxValid, // Received byte waiting.
	input wire logic rxReady, // User takes the byte.
	output logic [7:0] rxData, // Received byte.
	output logic busBusy, // Bus between start and stop.
	output logic arbLost, // Pulse: arbitration lost.
	output logic nackSeen, // Pulse: slave refused a byte.
	output logic selected // Addressed as slave.
);
	logic sclM_r, sclS_r, sclP_r, sdaM_r, sdaS_r, sdaP_r;
	logic sclRise, sclFall, startSeen, stopSeen, lineEvt;
	twi_pkg::mst_state_t mst_r;
	twi_pkg::slv_state_t slv_r;
	logic [15:0] tmr_r;
	logic [3:0] mBit_r, sBit_r;
	logic [7:0] mSh_r, sSh_r;
	logic mFirst_r, mRw_r, mLast_r, mStop_r, mPush_r, mScl_r, mSda_r;
	logic sRw_r, sScl_r, sSda_r;
	logic mTxDir, halfDone, mLose, mReady, mGo, bitDrive, sReady, addrHit;
	logic sRxDone, rxInValid, rxInReady;

	// ==========================================================
	// Line sampling
	// ==========================================================
	// Two flip-flops per line, then a third stage for edge finding.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			{sclM_r, sclS_r, sclP_r} <= {3{twi_pkg::LINE_IDLE}};
			{sdaM_r, sdaS_r, sdaP_r} <= {3{twi_pkg::LINE_IDLE}};
		end else if (ce) begin
			sclM_r <= bus.scl;
			sclS_r <= sclM_r;
			sclP_r <= sclS_r;
			sdaM_r <= bus.sda;
			sdaS_r <= sdaM_r;
			sdaP_r <= sdaS_r;
		end
	end

	// Edge and condition decode from the read-back line levels.
	assign sclRise = sclS_r & ~sclP_r;
	assign sclFall = ~sclS_r & sclP_r;
	assign startSeen = sclS_r & sclP_r & sdaP_r & ~sdaS_r;
	assign stopSeen = sclS_r & sclP_r & ~sdaP_r & sdaS_r;
	assign lineEvt = startSeen | stopSeen;

	// Bus occupancy seen by every node.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			busBusy <= 1'h0;
		end else if (ce) begin
			if (startSeen) begin
				busBusy <= 1'h1; // see [R20]
			end else if (stopSeen) begin
				busBusy <= 1'h0; // see [R20] [R9]
			end
		end
	end

	// ==========================================================
	// Master
	// ==========================================================
	// Address byte always goes out; later bytes follow the direction bit.
	assign mTxDir = mFirst_r | ~mRw_r; // see [R3]
	assign halfDone = tmr_r == (HALF_CYC - 16'h1);
	assign mLose = (mst_r == twi_pkg::M_HIGH) && sclS_r && (tmr_r == '0)
		&& (mBit_r < twi_pkg::ACK_BIT) && mTxDir && mSh_r[7] && !sdaS_r; // see [R15] [R16] [R17]
	assign mReady = !busBusy && sclS_r && sdaS_r && (slv_r == twi_pkg::S_IDLE); // see [R14]
	assign mGo = (mst_r == twi_pkg::M_IDLE) && mReady && txValid;

	// SDA level for the next bit: data, released ack slot, or receiver ack.
	always_comb begin
		if (mBit_r < twi_pkg::ACK_BIT) begin
			bitDrive = mTxDir & ~mSh_r[7];
		end else begin
			bitDrive = ~mTxDir & ~mLast_r; // see [R7] [R5]
		end
	end

	// Master sequencer with its half-period timer and shifter.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			mst_r <= twi_pkg::M_IDLE;
			tmr_r <= '0;
			mBit_r <= twi_pkg::BIT_RESET;
			mSh_r <= '0;
			{mFirst_r, mRw_r, mLast_r, mStop_r, mPush_r, mScl_r, mSda_r} <= '0;
			arbLost <= 1'h0;
			nackSeen <= 1'h0;
		end else if (ce) begin
			arbLost <= 1'h0;
			nackSeen <= 1'h0;
			tmr_r <= tmr_r + 16'h1;
			case (mst_r)
				twi_pkg::M_IDLE: begin
					mScl_r <= 1'h0; // see [R1]
					mSda_r <= 1'h0;
					tmr_r <= '0;
					if (mGo) begin
						mSda_r <= 1'h1; // see [R21] [R2]
						mSh_r <= txData;
						mRw_r <= txData[0];
						mLast_r <= txLast;
						{mFirst_r, mStop_r, mPush_r} <= 3'h4;
						mBit_r <= twi_pkg::BIT_RESET;
						mst_r <= twi_pkg::M_START;
					end
				end
				twi_pkg::M_START: begin
					if (halfDone) begin
						mScl_r <= 1'h1;
						tmr_r <= '0;
						mst_r <= twi_pkg::M_LOW;
					end
				end
				twi_pkg::M_LOW: begin
					if (tmr_r == '0) begin
						mSda_r <= bitDrive; // see [R22]
					end
					if (halfDone) begin
						mScl_r <= 1'h0;
						tmr_r <= '0;
						mst_r <= twi_pkg::M_HIGH;
					end
				end
				twi_pkg::M_HIGH: begin
					if (!sclS_r) begin
						tmr_r <= '0; // see [R12]
					end else if (mLose) begin
						arbLost <= 1'h1;
						mSda_r <= 1'h0;
						mst_r <= twi_pkg::M_IDLE;
					end else begin
						if (tmr_r == '0 && mBit_r < twi_pkg::ACK_BIT) begin
							mSh_r <= {mSh_r[6:0], sdaS_r}; // see [R23]
						end else if (tmr_r == '0 && mTxDir && sdaS_r) begin
							nackSeen <= 1'h1;
							mStop_r <= 1'h1;
						end
						if (halfDone) begin
							mScl_r <= 1'h1;
							tmr_r <= '0;
							if (mBit_r < twi_pkg::ACK_BIT) begin
								mBit_r <= mBit_r + 4'h1;
								mst_r <= twi_pkg::M_LOW;
							end else begin
								mPush_r <= ~mTxDir;
								mStop_r <= mStop_r | mLast_r;
								mst_r <= twi_pkg::M_HOLD;
							end
						end
					end
				end
				twi_pkg::M_HOLD: begin
					mSda_r <= mStop_r; // see [R11]
					if (mPush_r) begin
						mPush_r <= ~rxInReady;
					end else if (mStop_r) begin
						tmr_r <= '0;
						mst_r <= twi_pkg::M_STOPLO;
					end else if (txValid) begin
						mSh_r <= txData; // see [R10] [R9]
						mLast_r <= txLast;
						mFirst_r <= 1'h0;
						mBit_r <= twi_pkg::BIT_RESET;
						tmr_r <= '0;
						mst_r <= twi_pkg::M_LOW;
					end
				end
				twi_pkg::M_STOPLO: begin
					if (halfDone) begin
						mScl_r <= 1'h0; // see [R11]
						tmr_r <= '0;
						mst_r <= twi_pkg::M_STOPHI;
					end
				end
				twi_pkg::M_STOPHI: begin
					if (!sclS_r) begin
						tmr_r <= '0;
					end else if (halfDone) begin
						mSda_r <= 1'h0; // see [R11] [R2]
						tmr_r <= '0;
						mst_r <= twi_pkg::M_FREE;
					end
				end
				twi_pkg::M_FREE: begin
					if (halfDone) begin
						mst_r <= twi_pkg::M_IDLE;
					end
				end
				default: begin
					mst_r <= twi_pkg::M_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Slave
	// ==========================================================
	assign addrHit = (mst_r == twi_pkg::M_IDLE)
		&& (twi_pkg::addrMatch(sSh_r[7:1], OWN_ADDR)
		|| (GC_EN && sSh_r[7:1] == twi_pkg::GEN_CALL_ADDR && !sSh_r[0])); // see [R4] [R18]
	assign sRxDone = (slv_r == twi_pkg::S_RX) && sclFall && (sBit_r == twi_pkg::ACK_BIT);
	assign sReady = !lineEvt && (((slv_r == twi_pkg::S_ACK) && sclFall && sRw_r)
		|| (slv_r == twi_pkg::S_TXWAIT));

	// Slave sequencer; it follows every frame but drives only when addressed.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			slv_r <= twi_pkg::S_IDLE;
			sBit_r <= twi_pkg::BIT_RESET;
			sSh_r <= '0;
			{sRw_r, sScl_r, sSda_r, selected} <= '0;
		end else if (ce) begin
			if (lineEvt) begin
				slv_r <= startSeen ? twi_pkg::S_ADDR : twi_pkg::S_IDLE;
				sBit_r <= twi_pkg::BIT_RESET;
				{sScl_r, sSda_r, selected} <= '0; // see [R1]
			end else begin
				case (slv_r)
					twi_pkg::S_ADDR: begin
						if (sclRise) begin
							sSh_r <= {sSh_r[6:0], sdaS_r};
							sBit_r <= sBit_r + 4'h1;
						end else if (sclFall && sBit_r == twi_pkg::ACK_BIT) begin
							if (addrHit) begin
								sSda_r <= 1'h1; // see [R6]
								selected <= 1'h1;
								sRw_r <= sSh_r[0]; // see [R19]
								slv_r <= twi_pkg::S_ACK;
							end else begin
								slv_r <= twi_pkg::S_IDLE;
							end
						end
					end
					twi_pkg::S_ACK: begin
						sScl_r <= 1'h0;
						if (sclFall) begin
							sSda_r <= 1'h0;
							sBit_r <= twi_pkg::BIT_RESET;
							if (!sRw_r) begin
								slv_r <= twi_pkg::S_RX;
							end else if (txValid) begin
								sSh_r <= txData;
								sSda_r <= ~txData[7];
								slv_r <= twi_pkg::S_TX;
							end else begin
								sScl_r <= 1'h1; // see [R13] [R12]
								slv_r <= twi_pkg::S_TXWAIT;
							end
						end
					end
					twi_pkg::S_RX: begin
						if (sclRise) begin
							sSh_r <= {sSh_r[6:0], sdaS_r};
							sBit_r <= sBit_r + 4'h1;
						end else if (sRxDone && rxInReady) begin
							sSda_r <= 1'h1; // see [R8] [R5]
							slv_r <= twi_pkg::S_ACK;
						end else if (sRxDone) begin
							sScl_r <= 1'h1; // see [R13] [R12]
							slv_r <= twi_pkg::S_RXWAIT;
						end
					end
					twi_pkg::S_RXWAIT: begin
						if (rxInReady) begin
							sSda_r <= 1'h1; // see [R8] [R22]
							slv_r <= twi_pkg::S_ACK;
						end
					end
					twi_pkg::S_TXWAIT: begin
						if (txValid) begin
							sSh_r <= txData; // see [R22]
							sSda_r <= ~txData[7];
							slv_r <= twi_pkg::S_TX;
						end
					end
					twi_pkg::S_TX: begin
						sScl_r <= 1'h0;
						if (sclFall) begin
							sBit_r <= sBit_r + 4'h1;
							sSh_r <= {sSh_r[6:0], 1'h0};
							sSda_r <= (sBit_r == twi_pkg::LAST_BIT) ? 1'h0 : ~sSh_r[6];
							if (sBit_r == twi_pkg::LAST_BIT) begin
								slv_r <= twi_pkg::S_TXACK;
							end
						end
					end
					twi_pkg::S_TXACK: begin
						if (sclRise) begin
							slv_r <= sdaS_r ? twi_pkg::S_IDLE : twi_pkg::S_ACK;
						end
					end
					default: begin
						slv_r <= twi_pkg::S_IDLE;
					end
				endcase
			end
		end
	end

	// ==========================================================
	// User side and pins
	// ==========================================================
	assign txReady = ((mst_r == twi_pkg::M_IDLE) && mReady)
		|| ((mst_r == twi_pkg::M_HOLD) && !mPush_r && !mStop_r) || sReady;
	assign rxInValid = ((mst_r == twi_pkg::M_HOLD) && mPush_r) || sRxDone
		|| ((slv_r == twi_pkg::S_RXWAIT) && !lineEvt);

	// Received bytes wait here; a full buffer stretches the bus.
	two_entry_buffer #(.WIDTH(8), .DEPTH(twi_pkg::RX_DEPTH)) rxBuf (
		.clk(clk),
		.rstn(rstn),
		.ce(ce),
		.inValid(rxInValid),
		.inReady(rxInReady),
		.inData((mst_r == twi_pkg::M_HOLD) ? mSh_r : sSh_r),
		.outValid(rxValid),
		.outReady(rxReady),
		.outData(rxData)
	);

	// Open-drain pins: only ever pull low or release.
	assign bus.devSclOut = 1'h0; // see [R23]
	assign bus.devSdaOut = 1'h0;
	assign bus.devSclOe = mScl_r | sScl_r;
	assign bus.devSdaOe = mSda_r | sSda_r;
endmodule // twi_node

`default_nettype wire

// ### logic/twi_partner.sv
/*
 * Far end of the bus: a plain addressed slave, receiver or transmitter.
 * Assumes the lines arrive asynchronously; the user side shares its clock.
 */
`timescale 1ns/100ps
`default_nettype none

module twi_partner #(
	parameter logic [6:0] OWN_ADDR = 7'h51
) (
	input wire logic clk, // System clock.
	input wire logic rstn, // Synchronous reset, active low.
	input wire logic ce, // Clock enable; low freezes all state.
	twi_bus_if.far bus, // Shared SCL and SDA lines.
	output logic rxValid, // Received byte held.
	input wire logic rxReady, // User takes the byte.
	output logic [7:0] rxData, // Received byte.
	input wire logic txValid, // Byte offered for a read.
	output logic txReady, // Byte taken this cycle.
	input wire logic [7:0] txData, // Byte to send.
	output logic selected // Addressed by a master.
);
	logic sclM_r, sclS_r, sclP_r, sdaM_r, sdaS_r, sdaP_r;
	logic sclRise, sclFall, startSeen, stopSeen;
	twi_pkg::slv_state_t st_r;
	logic [3:0] bit_r;
	logic [7:0] sh_r;
	logic rw_r, scl_r, sda_r, byteDone;

	// Line synchronisers and edge stage.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			{sclM_r, sclS_r, sclP_r} <= {3{twi_pkg::LINE_IDLE}};
			{sdaM_r, sdaS_r, sdaP_r} <= {3{twi_pkg::LINE_IDLE}};
		end else if (ce) begin
			{sclM_r, sclS_r, sclP_r} <= {bus.scl, sclM_r, sclS_r};
			{sdaM_r, sdaS_r, sdaP_r} <= {bus.sda, sdaM_r, sdaS_r};
		end
	end

	assign sclRise = sclS_r & ~sclP_r;
	assign sclFall = ~sclS_r & sclP_r;
	assign startSeen = sclS_r & sclP_r & sdaP_r & ~sdaS_r;
	assign stopSeen = sclS_r & sclP_r & ~sdaP_r & sdaS_r;
	assign byteDone = (st_r == twi_pkg::S_RX) && sclFall && (bit_r == twi_pkg::ACK_BIT);
	assign txReady = !startSeen && !stopSeen && txValid && (((st_r == twi_pkg::S_ACK)
		&& sclFall && rw_r) || (st_r == twi_pkg::S_TXWAIT));

	// Slave sequencer; stretches SCL while its byte holder is full.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			st_r <= twi_pkg::S_IDLE;
			bit_r <= twi_pkg::BIT_RESET;
			{sh_r, rxData} <= '0;
			{rw_r, scl_r, sda_r, selected, rxValid} <= '0;
		end else if (ce) begin
			if (rxReady) begin
				rxValid <= 1'h0;
			end
			if (startSeen || stopSeen) begin
				st_r <= startSeen ? twi_pkg::S_ADDR : twi_pkg::S_IDLE;
				bit_r <= twi_pkg::BIT_RESET;
				{scl_r, sda_r, selected} <= '0;
			end else begin
				case (st_r)
					twi_pkg::S_ADDR: begin
						if (sclRise) begin
							sh_r <= {sh_r[6:0], sdaS_r};
							bit_r <= bit_r + 4'h1;
						end else if (sclFall && bit_r == twi_pkg::ACK_BIT) begin
							if (twi_pkg::addrMatch(sh_r[7:1], OWN_ADDR)) begin
								sda_r <= 1'h1;
								selected <= 1'h1;
								rw_r <= sh_r[0];
								st_r <= twi_pkg::S_ACK;
							end else begin
								st_r <= twi_pkg::S_IDLE;
							end
						end
					end
					twi_pkg::S_ACK: begin
						scl_r <= 1'h0;
						if (sclFall) begin
							sda_r <= 1'h0;
							bit_r <= twi_pkg::BIT_RESET;
							if (!rw_r) begin
								st_r <= twi_pkg::S_RX;
							end else if (txValid) begin
								sh_r <= txData;
								sda_r <= ~txData[7];
								st_r <= twi_pkg::S_TX;
							end else begin
								scl_r <= 1'h1; // see [R12]
								st_r <= twi_pkg::S_TXWAIT;
							end
						end
					end
					twi_pkg::S_RX: begin
						if (sclRise) begin
							sh_r <= {sh_r[6:0], sdaS_r};
							bit_r <= bit_r + 4'h1;
						end else if (byteDone && !rxValid) begin
							rxData <= sh_r; // see [R5]
							rxValid <= 1'h1;
							sda_r <= 1'h1;
							st_r <= twi_pkg::S_ACK;
						end else if (byteDone) begin
							scl_r <= 1'h1; // see [R12]
							st_r <= twi_pkg::S_RXWAIT;
						end
					end
					twi_pkg::S_RXWAIT: begin
						if (!rxValid) begin
							rxData <= sh_r;
							rxValid <= 1'h1;
							sda_r <= 1'h1; // see [R22]
							st_r <= twi_pkg::S_ACK;
						end
					end
					twi_pkg::S_TXWAIT: begin
						if (txValid) begin
							sh_r <= txData;
							sda_r <= ~txData[7];
							st_r <= twi_pkg::S_TX;
						end
					end
					twi_pkg::S_TX: begin
						scl_r <= 1'h0;
						if (sclFall) begin
							bit_r <= bit_r + 4'h1;
							sh_r <= {sh_r[6:0], 1'h0};
							sda_r <= (bit_r == twi_pkg::LAST_BIT) ? 1'h0 : ~sh_r[6]; // see [R22]
							if (bit_r == twi_pkg::LAST_BIT) begin
								st_r <= twi_pkg::S_TXACK;
							end
						end
					end
					twi_pkg::S_TXACK: begin
						if (sclRise) begin
							st_r <= sdaS_r ? twi_pkg::S_IDLE : twi_pkg::S_ACK; // see [R9]
						end
					end
					default: begin
						st_r <= twi_pkg::S_IDLE;
					end
				endcase
			end
		end
	end

	// Open-drain pins, released whenever the bus is idle.
	assign bus.farSclOut = 1'h0; // see [R23] [R1]
	assign bus.farSdaOut = 1'h0;
	assign bus.farSclOe = scl_r;
	assign bus.farSdaOe = sda_r;
endmodule // twi_partner

`default_nettype wire

// ### logic/twi_pkg.sv
/*
 * Shared constants, state types and address decoding for the two-wire bus
 * node and its partner.
 * Assumes a 200 MHz system clock on both ends.
 */
`default_nettype none

package twi_pkg;

	// ==========================================================
	// Timing
	// ==========================================================
	localparam int CLK_PERIOD_NS = 5;
	// Half of one SCL period at 100 kbit/s.
	localparam int SCL_HALF_NS = 5000;
	// Least time, so it rounds up to whole cycles.
	localparam int SCL_HALF_CYC = (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==========================================================
	// Frame layout and reset values
	// ==========================================================
	localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
	localparam logic [3:0] ACK_BIT = 4'h8;
	localparam logic [3:0] LAST_BIT = 4'h7;
	localparam logic [3:0] BIT_RESET = 4'h0;
	localparam logic LINE_IDLE = 1'h1;
	localparam int RX_DEPTH = 2;

	// ==========================================================
	// State types
	// ==========================================================
	typedef enum logic [2:0] {
		M_IDLE = 3'b000,
		M_START = 3'b001,
		M_LOW = 3'b010,
		M_HIGH = 3'b011,
		M_HOLD = 3'b100,
		M_STOPLO = 3'b101,
		M_STOPHI = 3'b110,
		M_FREE = 3'b111
	} mst_state_t;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_ADDR = 3'b001,
		S_ACK = 3'b010,
		S_RX = 3'b011,
		S_RXWAIT = 3'b100,
		S_TX = 3'b101,
		S_TXWAIT = 3'b110,
		S_TXACK = 3'b111
	} slv_state_t;

	// ==========================================================
	// Address decoding
	// ==========================================================
	// Groups 0000xxx and 1111xxx are reserved; 11110xx also covers 10-bit headers.
	function automatic logic isReserved(input logic [6:0] a);
		return (a[6:3] == 4'h0) || (a[6:3] == 4'hf);
	endfunction

	// True when the received address names a usable own address.
	function automatic logic addrMatch(input logic [6:0] a, input logic [6:0] own);
		return (a == own) && !isReserved(own);
	endfunction

endpackage

`default_nettype wire

// ### logic/two_entry_buffer.sv
/*
 * Small FIFO with valid and ready on both sides.
 * Assumes one clock domain; the drain side may stall freely.
 */
`timescale 1ns/100ps
`default_nettype none

module two_entry_buffer #(
	parameter int WIDTH = 8,
	parameter int DEPTH = twi_pkg::RX_DEPTH
) (
	input wire logic clk, // System clock.
	input wire logic rstn, // Synchronous reset, active low.
	input wire logic ce, // Clock enable.
	input wire logic inValid, // Fill side offers a word.
	output logic inReady, // Room for a word.
	input wire logic [WIDTH-1:0] inData, // Word to store.
	output logic outValid, // A word is held.
	input wire logic outReady, // Drain side takes the word.
	output logic [WIDTH-1:0] outData // Oldest word.
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_r;
	logic [AW-1:0] rdPtr_r;
	logic [AW:0] count_r;
	logic push;
	logic pop;

	// Pointer step with wrap at the depth.
	function automatic logic [AW-1:0] nextPtr(input logic [AW-1:0] p);
		return (p == (AW)'(DEPTH - 1)) ? '0 : p + (AW)'(1);
	endfunction

	// Honest full and empty flags.
	assign inReady = count_r != (AW + 1)'(DEPTH);
	assign outValid = count_r != '0;
	assign outData = mem[rdPtr_r];
	assign push = inValid & inReady;
	assign pop = outValid & outReady;

	// Storage array.
	always_ff @(posedge clk) begin
		if (ce && push) begin
			mem[wrPtr_r] <= inData;
		end
	end

	// Pointers and fill count.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end else if (ce) begin
			if (push) begin
				wrPtr_r <= nextPtr(wrPtr_r);
			end
			if (pop) begin
				rdPtr_r <= nextPtr(rdPtr_r);
			end
			count_r <= count_r + (AW + 1)'(push) - (AW + 1)'(pop);
		end
	end
endmodule // two_entry_buffer

`default_nettype wire
